// ### rtl/cpu_state_pkg.sv
package cpu_state_pkg;
  // data memory and program counter geometry
  localparam int RAM_SIZE    = 256;
  localparam int RAM_AW      = 8;
  localparam int PC_W        = 12;
  localparam int ONCHIP_BITS = 11;
  localparam int SP_W        = 3;

  // fixed data memory map
  localparam logic [RAM_AW-1:0] STACK_BASE = 8'h08;
  localparam logic [2:0]        BANK0_HI   = 3'h0;
  localparam logic [2:0]        BANK1_HI   = 3'h3;
  localparam logic [2:0]        PTR_A_IDX  = 3'h0;
  localparam logic [2:0]        PTR_B_IDX  = 3'h1;

  // status word bit positions
  localparam int SW_SP_LO = 0;
  localparam int SW_SP_HI = 2;
  localparam int SW_ONE   = 3;
  localparam int SW_BANK  = 4;
  localparam int SW_FLAG  = 5;
  localparam int SW_AUX   = 6;
  localparam int SW_CARRY = 7;
  localparam logic [7:0] SW_RESET = 8'h00;
  localparam logic [7:0] SW_ONE_MASK = 8'h08;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PC     = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_ACC    = 8'h10;

  // command word fields
  localparam int CMD_OP_LO  = 0;
  localparam int CMD_OP_HI  = 3;
  localparam int CMD_REG_LO = 4;
  localparam int CMD_REG_HI = 6;
  localparam int CMD_DAT_LO = 8;
  localparam int CMD_DAT_HI = 15;
  localparam int CMD_TGT_LO = 16;
  localparam int CMD_TGT_HI = 27;
  localparam int RES_FLAG   = 8;

  // alu constants
  localparam logic [3:0] NIB_NINE = 4'h9;
  localparam logic [7:0] ADJ_LO   = 8'h06;
  localparam logic [7:0] ADJ_HI   = 8'h60;

  typedef enum logic [3:0] {
    OP_NOP, OP_CALL, OP_RET, OP_EXIT_RESTORING_STATUS, OP_LOOP, OP_BANK, OP_FCLR, OP_FCPL,
    OP_ADD, OP_DADJ, OP_WREG, OP_RREG, OP_WIND, OP_RIND, OP_ACC2SW, OP_SW2ACC
  } op_e;
endpackage

// ### rtl/cpu_state_core.sv
// Contract
// - ram 256 bytes, pointers reach all locations
// - bank 0 registers at locations 0-7
// - bank 1 registers at locations 24-31
// - locations 24-31 stay ordinary indirect storage
// - stack area 8-23 also indirect RAM
// - loop decrements register, branches on nonzero
// - reset clears program counter
// - low pc bits on-chip, upper mean external
// - call saves pc into pair by pointer
// - pointer 000 is 8/9, then increment
// - stack pointer wraps silently both ways
// - return decrements pointer then loads pc
// - call saves upper status nibble too
// - restoring return reloads nibble, plain keeps
// - status word moves whole to/from accumulator
// - status bits 0-2 are stack pointer
// - status bit 3 reads as one
// - status bit 4 selects bank
// - bit 5 user flag clear/complement/test
// - bit 6 low-nibble carry for adjust
// - bit 7 carry on accumulator overflow
module cpu_state_core (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // program fetch
  output logic [cpu_state_pkg::ONCHIP_BITS-1:0] ONCHIP_ADDR,
  output logic                                  EXT_FETCH
);
  logic [7:0]  ram_r [cpu_state_pkg::RAM_SIZE];
  logic [7:0]  sw_r;
  logic [11:0] pc_r;
  logic [11:0] pc_nxt;
  logic [7:0]  acc_r;
  logic [8:0]  result_r;
  logic        pready_r;
  logic        ext_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        cmd;
  cpu_state_pkg::op_e op;
  logic [2:0]  reg_n;
  logic [7:0]  dat;
  logic [11:0] tgt;
  logic [2:0]  sp;
  logic [2:0]  sp_dec;
  logic [7:0]  push_lo;
  logic [7:0]  pop_lo;
  logic [7:0]  wreg_addr;
  logic [7:0]  ind_addr;
  logic [7:0]  wreg_val;
  logic [7:0]  wreg_dec;
  logic [8:0]  sum;
  logic        aux;
  logic [7:0]  adj1;
  logic [8:0]  adj2;
  logic [7:0]  sw_view;

  // ram write ports, b only for the odd stack byte
  logic        we_a;
  logic [7:0]  wa_addr;
  logic [7:0]  wa_data;
  logic        we_b;
  logic [7:0]  wb_addr;
  logic [7:0]  wb_data;

  assign access = PSEL && PENABLE && pready_r;
  assign wr     = access && PWRITE;
  assign rd     = PSEL && PENABLE && !pready_r && !PWRITE;
  assign mapped = (PADDR == cpu_state_pkg::OFS_STATUS) || (PADDR == cpu_state_pkg::OFS_PC)
               || (PADDR == cpu_state_pkg::OFS_CMD) || (PADDR == cpu_state_pkg::OFS_RESULT)
               || (PADDR == cpu_state_pkg::OFS_ACC);
  assign cmd    = wr && (PADDR == cpu_state_pkg::OFS_CMD);
  assign op     = cpu_state_pkg::op_e'(PWDATA[cpu_state_pkg::CMD_OP_HI:cpu_state_pkg::CMD_OP_LO]);
  assign reg_n  = PWDATA[cpu_state_pkg::CMD_REG_HI:cpu_state_pkg::CMD_REG_LO];
  assign dat    = PWDATA[cpu_state_pkg::CMD_DAT_HI:cpu_state_pkg::CMD_DAT_LO];
  assign tgt    = PWDATA[cpu_state_pkg::CMD_TGT_HI:cpu_state_pkg::CMD_TGT_LO];

  assign sp      = sw_r[cpu_state_pkg::SW_SP_HI:cpu_state_pkg::SW_SP_LO];
  assign sp_dec  = sp - 3'h1;
  assign push_lo = cpu_state_pkg::STACK_BASE + {4'h0, sp, 1'b0};
  assign pop_lo  = cpu_state_pkg::STACK_BASE + {4'h0, sp_dec, 1'b0};

  // working register address from bank bit
  assign wreg_addr = {2'b00,
                      sw_r[cpu_state_pkg::SW_BANK] ? cpu_state_pkg::BANK1_HI
                                                   : cpu_state_pkg::BANK0_HI,
                      reg_n};
  assign wreg_val  = ram_r[wreg_addr];
  assign wreg_dec  = wreg_val - 8'h01;
  // pointer a or b of the active bank reaches any byte
  assign ind_addr  = ram_r[{2'b00,
                      sw_r[cpu_state_pkg::SW_BANK] ? cpu_state_pkg::BANK1_HI
                                                   : cpu_state_pkg::BANK0_HI,
                      reg_n[0] ? cpu_state_pkg::PTR_B_IDX
                               : cpu_state_pkg::PTR_A_IDX}];

  assign sum  = {1'b0, acc_r} + {1'b0, dat};
  assign aux  = ({1'b0, acc_r[3:0]} + {1'b0, dat[3:0]}) > 5'h0F;
  assign adj1 = ((acc_r[3:0] > cpu_state_pkg::NIB_NINE) || sw_r[cpu_state_pkg::SW_AUX])
                ? acc_r + cpu_state_pkg::ADJ_LO : acc_r;
  assign adj2 = ((adj1[7:4] > cpu_state_pkg::NIB_NINE) || sw_r[cpu_state_pkg::SW_CARRY])
                ? {1'b0, adj1} + {1'b0, cpu_state_pkg::ADJ_HI} : {1'b0, adj1};
  assign sw_view = sw_r | cpu_state_pkg::SW_ONE_MASK;

  always_comb begin
    we_a    = 1'b0;
    wa_addr = wreg_addr;
    wa_data = dat;
    we_b    = 1'b0;
    wb_addr = push_lo + 8'h01;
    wb_data = {sw_r[7:4], pc_r[11:8]};
    if (cmd) begin
      case (op)
        cpu_state_pkg::OP_CALL: begin
          we_a    = 1'b1;
          wa_addr = push_lo;
          wa_data = pc_r[7:0];
          we_b    = 1'b1;
        end
        cpu_state_pkg::OP_LOOP: begin
          we_a    = 1'b1;
          wa_data = wreg_dec;
        end
        cpu_state_pkg::OP_WREG: we_a = 1'b1;
        cpu_state_pkg::OP_WIND: begin
          we_a    = 1'b1;
          wa_addr = ind_addr;
        end
        default: we_a = 1'b0;
      endcase
    end
  end

  // data memory, one flip-flop byte per entry
  for (genvar i = 0; i < cpu_state_pkg::RAM_SIZE; i++) begin : g_ram
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        ram_r[i] <= 8'h00;
      end else if (we_a && wa_addr == 8'(i)) begin
        ram_r[i] <= wa_data;
      end else if (we_b && wb_addr == 8'(i)) begin
        ram_r[i] <= wb_data;
      end
    end
  end

  always_comb begin
    pc_nxt = pc_r;
    if (wr && PADDR == cpu_state_pkg::OFS_PC) begin
      pc_nxt = PWDATA[11:0];
    end else if (cmd) begin
      case (op)
        cpu_state_pkg::OP_CALL: pc_nxt = tgt;
        cpu_state_pkg::OP_RET,
        cpu_state_pkg::OP_EXIT_RESTORING_STATUS: pc_nxt = {ram_r[pop_lo + 8'h01][3:0], ram_r[pop_lo]};
        cpu_state_pkg::OP_LOOP: pc_nxt = (wreg_dec != 8'h00) ? tgt : pc_r;
        default:                pc_nxt = pc_r;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pc_r  <= 12'h000;
      ext_r <= 1'b0;
    end else begin
      pc_r  <= pc_nxt;
      ext_r <= |pc_nxt[11:cpu_state_pkg::ONCHIP_BITS];
    end
  end

  // status word
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_r <= cpu_state_pkg::SW_RESET;
    end else if (wr && PADDR == cpu_state_pkg::OFS_STATUS) begin
      sw_r <= PWDATA[7:0];
    end else if (cmd) begin
      case (op)
        cpu_state_pkg::OP_CALL: sw_r[2:0] <= sp + 3'h1;
        cpu_state_pkg::OP_RET:  sw_r[2:0] <= sp_dec;
        cpu_state_pkg::OP_EXIT_RESTORING_STATUS: sw_r <= {ram_r[pop_lo + 8'h01][7:4], sw_r[3], sp_dec};
        cpu_state_pkg::OP_BANK: sw_r[cpu_state_pkg::SW_BANK] <= dat[0];
        cpu_state_pkg::OP_FCLR: sw_r[cpu_state_pkg::SW_FLAG] <= 1'b0;
        cpu_state_pkg::OP_FCPL: sw_r[cpu_state_pkg::SW_FLAG] <= !sw_r[cpu_state_pkg::SW_FLAG];
        cpu_state_pkg::OP_ADD: begin
          sw_r[cpu_state_pkg::SW_CARRY] <= sum[8];
          sw_r[cpu_state_pkg::SW_AUX]   <= aux;
        end
        cpu_state_pkg::OP_DADJ: begin
          sw_r[cpu_state_pkg::SW_CARRY] <= adj2[8] | sw_r[cpu_state_pkg::SW_CARRY];
        end
        cpu_state_pkg::OP_ACC2SW: sw_r <= acc_r;
        default: sw_r <= sw_r;
      endcase
    end
  end

  // accumulator
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      acc_r <= 8'h00;
    end else if (wr && PADDR == cpu_state_pkg::OFS_ACC) begin
      acc_r <= PWDATA[7:0];
    end else if (cmd) begin
      case (op)
        cpu_state_pkg::OP_ADD:    acc_r <= sum[7:0];
        cpu_state_pkg::OP_DADJ:   acc_r <= adj2[7:0];
        cpu_state_pkg::OP_SW2ACC: acc_r <= sw_view;
        default:                  acc_r <= acc_r;
      endcase
    end
  end

  // result: read byte and branch/test flag
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      result_r <= 9'h000;
    end else if (cmd) begin
      case (op)
        cpu_state_pkg::OP_RREG: result_r <= {1'b0, wreg_val};
        cpu_state_pkg::OP_RIND: result_r <= {1'b0, ram_r[ind_addr]};
        cpu_state_pkg::OP_LOOP: result_r <= {wreg_dec != 8'h00, wreg_dec};
        default: result_r <= {sw_r[cpu_state_pkg::SW_FLAG], wreg_val};
      endcase
    end
  end

  // apb: one wait state, read data latched with pready
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= PSEL && PENABLE && !pready_r;
      pslverr_r <= PSEL && PENABLE && !pready_r && !mapped;
      if (rd) begin
        case (PADDR)
          cpu_state_pkg::OFS_STATUS: prdata_r <= {24'h000000, sw_view};
          cpu_state_pkg::OFS_PC:     prdata_r <= {20'h00000, pc_r};
          cpu_state_pkg::OFS_RESULT: prdata_r <= {23'h0, result_r};
          cpu_state_pkg::OFS_ACC:    prdata_r <= {24'h000000, acc_r};
          default:                   prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign ONCHIP_ADDR = pc_r[cpu_state_pkg::ONCHIP_BITS-1:0];
  assign EXT_FETCH   = ext_r;

  // checks
  sequence s_cmd(logic [3:0] o);
    cmd && op == cpu_state_pkg::op_e'(o);
  endsequence

  property p_call_sp;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h1) |=> sp == $past(sp) + 3'h1;
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("push did not advance pointer");

  property p_call_store;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h1) |=> ram_r[$past(push_lo)] == $past(pc_r[7:0]) && pc_r == $past(tgt);
  endproperty
  a_call_store: assert property (p_call_store) else $error("pc not saved on push");

  property p_call_nibble;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h1) |=> ram_r[$past(push_lo) + 8'h01] == {$past(sw_r[7:4]), $past(pc_r[11:8])};
  endproperty
  a_call_nibble: assert property (p_call_nibble) else $error("odd stack byte wrong");

  property p_call_ret;
    @(posedge CLK) disable iff (!NRST)
      cmd && (op == cpu_state_pkg::OP_RET || op == cpu_state_pkg::OP_EXIT_RESTORING_STATUS)
        |=> pc_r == {$past(ram_r[pop_lo + 8'h01][3:0]), $past(ram_r[pop_lo])}
            && sp == $past(sp_dec);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("pc not reloaded on return");

  property p_ret_keeps;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h2) |=> sw_r[7:3] == $past(sw_r[7:3]);
  endproperty
  a_ret_keeps: assert property (p_ret_keeps) else $error("plain return changed status");

  property p_exit_restoring_status;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h3) |=> sw_r[7:4] == $past(ram_r[pop_lo + 8'h01][7:4]);
  endproperty
  a_exit_restoring_status: assert property (p_exit_restoring_status) else $error("status nibble not restored");

  property p_loop;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h4) |=> ram_r[$past(wreg_addr)] == $past(wreg_val) - 8'h01
                      && pc_r == (($past(wreg_val) != 8'h01) ? $past(tgt) : $past(pc_r));
  endproperty
  a_loop: assert property (p_loop) else $error("loop step wrong");

  property p_status_read;
    @(posedge CLK) disable iff (!NRST)
      rd && PADDR == cpu_state_pkg::OFS_STATUS |=> PREADY && PRDATA[3];
  endproperty
  a_status_read: assert property (p_status_read) else $error("bit 3 not one");

  property p_ext;
    @(posedge CLK) disable iff (!NRST)
      EXT_FETCH == (|pc_r[11:cpu_state_pkg::ONCHIP_BITS]);
  endproperty
  a_ext: assert property (p_ext) else $error("external fetch flag wrong");

  property p_bank;
    @(posedge CLK) disable iff (!NRST)
      s_cmd(4'h5) |=> sw_r[4] == $past(dat[0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank bit not updated");
endmodule // cpu_state_core

// ### tb/seq_model.sv
module seq_model (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  int timeouts = 0;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // gap adds idle cycles, modelling a slow sequencer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input int gap, output logic [31:0] r, output logic e);
    int n;
    repeat (gap + 1) @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) timeouts++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // seq_model

// ### tb/test_cpu_state_ram_stack_psw.sv
module test_cpu_state_ram_stack_psw;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, x) begin \
    samples_checked++; \
    if ((g) !== (x)) begin \
      err_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, (g), (x)); \
    end \
  end

  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, EXT_FETCH;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rv;
  logic [10:0] ONCHIP_ADDR;
  logic        er;
  int          err_count = 0;
  int          samples_checked = 0;
  int          seed = 32'hcde4;
  logic [7:0]  sw, v, a, d;
  logic [11:0] p, t;
  logic [7:0]  ev[8], od[8];
  logic [2:0]  sp;

  always #20 CLK = ~CLK;

  cpu_state_core cpu_state_core_inst (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ONCHIP_ADDR(ONCHIP_ADDR), .EXT_FETCH(EXT_FETCH));
  seq_model seq_model_inst (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  task summarize;
    err_count += seq_model_inst.timeouts;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task xf(input logic w, input logic [7:0] ad, input logic [31:0] dv);
    seq_model_inst.xfer(w, ad, dv, {$random(seed)} % 3, rv, er);
    if (seq_model_inst.timeouts > 0) summarize();
  endtask

  task cmd(input cpu_state_pkg::op_e op, input logic [2:0] n, input logic [7:0] dv,
           input logic [11:0] tg);
    xf(1'b1, cpu_state_pkg::OFS_CMD, {4'h0, tg, dv, 1'b0, n, op});
  endtask

  task set_sw(input logic [7:0] s);
    xf(1'b1, cpu_state_pkg::OFS_ACC, {24'h0, s});
    cmd(cpu_state_pkg::OP_ACC2SW, 3'h0, 8'h00, 12'h000);
    sw = s;
  endtask

  // pointer a of the active bank is overwritten
  task rdind(input logic [7:0] loc);
    cmd(cpu_state_pkg::OP_WREG, 3'h0, loc, 12'h000);
    cmd(cpu_state_pkg::OP_RIND, 3'h0, 8'h00, 12'h000);
    xf(1'b0, cpu_state_pkg::OFS_RESULT, 32'h0);
  endtask

  task chk_fetch(input logic [11:0] pv);
    xf(1'b1, cpu_state_pkg::OFS_PC, {20'h0, pv});
    repeat (2) @(posedge CLK);
    #1;
    `CHK(ONCHIP_ADDR, pv[10:0]);
    `CHK(EXT_FETCH, pv[11]);
  endtask

  function automatic logic [7:0] rdsw(input logic [7:0] s);
    return s | cpu_state_pkg::SW_ONE_MASK;
  endfunction

  function automatic logic [9:0] add_exp(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    return {s[8], ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F, s[7:0]};
  endfunction

  initial begin
    repeat (60000) @(posedge CLK);
    err_count++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    xf(1'b0, cpu_state_pkg::OFS_PC, 32'h0);
    `CHK(rv, 32'h0);
    xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
    `CHK(rv, 32'h08);
    xf(1'b0, 8'h40, 32'h0);
    `CHK({er, rv}, 33'h100000000);
    xf(1'b1, 8'h44, 32'hFFFF);
    `CHK(er, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      set_sw(v);
      xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
      `CHK(rv[7:0], rdsw(v));
      xf(1'b1, cpu_state_pkg::OFS_ACC, 32'h0);
      cmd(cpu_state_pkg::OP_SW2ACC, 3'h0, 8'h00, 12'h000);
      xf(1'b0, cpu_state_pkg::OFS_ACC, 32'h0);
      `CHK(rv[7:0], rdsw(v));
    end
    set_sw(8'h00);
    cmd(cpu_state_pkg::OP_WREG, 3'h3, 8'hA5, 12'h000);
    cmd(cpu_state_pkg::OP_BANK, 3'h0, 8'h01, 12'h000);
    xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
    `CHK(rv[7:0], 8'h18);
    cmd(cpu_state_pkg::OP_WREG, 3'h2, 8'h5A, 12'h000);
    cmd(cpu_state_pkg::OP_WREG, 3'h1, 8'h03, 12'h000);
    cmd(cpu_state_pkg::OP_RIND, 3'h1, 8'h00, 12'h000);
    xf(1'b0, cpu_state_pkg::OFS_RESULT, 32'h0);
    `CHK(rv[7:0], 8'hA5);
    cmd(cpu_state_pkg::OP_BANK, 3'h0, 8'h00, 12'h000);
    cmd(cpu_state_pkg::OP_RREG, 3'h2, 8'h00, 12'h000);
    xf(1'b0, cpu_state_pkg::OFS_RESULT, 32'h0);
    `CHK(rv[7:0], 8'h00);
    rdind(8'd26);
    `CHK(rv[7:0], 8'h5A);
    rdind(8'd25);
    `CHK(rv[7:0], 8'h03);
    cmd(cpu_state_pkg::OP_WREG, 3'h1, 8'hFF, 12'h000);
    cmd(cpu_state_pkg::OP_WIND, 3'h1, 8'h3C, 12'h000);
    rdind(8'hFF);
    `CHK(rv[7:0], 8'h3C);
    set_sw(8'h20);
    for (int i = 0; i < 3; i++) begin
      cmd(cpu_state_pkg::op_e'((i == 0) ? cpu_state_pkg::OP_FCLR : cpu_state_pkg::OP_FCPL),
          3'h0, 8'h00, 12'h000);
      xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
      `CHK(rv[5], (i == 1));
      cmd(cpu_state_pkg::OP_NOP, 3'h0, 8'h00, 12'h000);
      xf(1'b0, cpu_state_pkg::OFS_RESULT, 32'h0);
      `CHK(rv[8], (i == 1));
    end
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 8'hFF : (i == 1) ? 8'h0F : 8'($random(seed));
      d = (i < 2) ? 8'h01 : 8'($random(seed));
      xf(1'b1, cpu_state_pkg::OFS_ACC, {24'h0, a});
      cmd(cpu_state_pkg::OP_ADD, 3'h0, d, 12'h000);
      xf(1'b0, cpu_state_pkg::OFS_ACC, 32'h0);
      `CHK(rv[7:0], add_exp(a, d)[7:0]);
      xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
      `CHK(rv[7:6], add_exp(a, d)[9:8]);
    end
    xf(1'b1, cpu_state_pkg::OFS_ACC, 32'h08);
    cmd(cpu_state_pkg::OP_ADD, 3'h0, 8'h08, 12'h000);
    cmd(cpu_state_pkg::OP_DADJ, 3'h0, 8'h00, 12'h000);
    xf(1'b0, cpu_state_pkg::OFS_ACC, 32'h0);
    `CHK(rv[7:0], 8'h16);
    set_sw(8'h00);
    xf(1'b1, cpu_state_pkg::OFS_PC, 32'h123);
    cmd(cpu_state_pkg::OP_WREG, 3'h5, 8'h01, 12'h000);
    for (int i = 0; i < 2; i++) begin
      cmd(cpu_state_pkg::OP_LOOP, 3'h5, 8'h00, 12'h456);
      xf(1'b0, cpu_state_pkg::OFS_RESULT, 32'h0);
      `CHK(rv[8:0], (i == 0) ? 9'h000 : 9'h1FF);
      xf(1'b0, cpu_state_pkg::OFS_PC, 32'h0);
      `CHK(rv[11:0], (i == 0) ? 12'h123 : 12'h456);
    end
    chk_fetch(12'hA5B);
    chk_fetch(12'h3C4);
    sp = 3'h0;
    for (int i = 0; i < 9; i++) begin
      p = 12'($random(seed));
      t = 12'($random(seed));
      v = 8'($random(seed));
      xf(1'b1, cpu_state_pkg::OFS_PC, {20'h0, p});
      set_sw({v[7:4], 1'b0, sp});
      cmd(cpu_state_pkg::OP_CALL, 3'h0, 8'h00, t);
      ev[sp] = p[7:0];
      od[sp] = {v[7:4], p[11:8]};
      sp = sp + 3'h1;
      sw[2:0] = sp;
      xf(1'b0, cpu_state_pkg::OFS_PC, 32'h0);
      `CHK(rv[11:0], t);
      xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
      `CHK(rv[7:0], rdsw(sw));
    end
    for (int k = 0; k < 8; k++) begin
      rdind(8'(8 + 2 * k));
      `CHK(rv[7:0], ev[k]);
      rdind(8'(9 + 2 * k));
      `CHK(rv[7:0], od[k]);
    end
    for (int i = 0; i < 3; i++) begin
      cmd(cpu_state_pkg::op_e'((i == 1) ? cpu_state_pkg::OP_EXIT_RESTORING_STATUS : cpu_state_pkg::OP_RET),
          3'h0, 8'h00, 12'h000);
      sp = sp - 3'h1;
      if (i == 1) sw[7:4] = od[sp][7:4];
      sw[2:0] = sp;
      xf(1'b0, cpu_state_pkg::OFS_PC, 32'h0);
      `CHK(rv[11:0], {od[sp][3:0], ev[sp]});
      xf(1'b0, cpu_state_pkg::OFS_STATUS, 32'h0);
      `CHK(rv[7:0], rdsw(sw));
    end
    @(posedge CLK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    xf(1'b0, cpu_state_pkg::OFS_PC, 32'h0);
    `CHK(rv, 32'h0);
    summarize();
  end
endmodule // test_cpu_state_ram_stack_psw
